// >>> design/hm29_pkg.sv
/*
  constants shared by the homing method 29 sequencer and its input conditioner.
  assumes one 100 MHz system clock and a synchronous active-high reset.
*/
package hm29_pkg;

  // ----------------------------------------------------------------
  // switch input lanes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_IN     = 3;
  localparam int unsigned IDX_ORIGIN = 0;
  localparam int unsigned IDX_LIMIT  = 1;
  localparam int unsigned IDX_DECEL  = 2;
  localparam logic [2:0]  PIN_RESET  = 3'h0;

  // ----------------------------------------------------------------
  // speed commands to the speed loop
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HM29_CMD_ZERO     = 3'h0,
    HM29_CMD_REV_HIGH = 3'h1,
    HM29_CMD_REV_LOW  = 3'h2,
    HM29_CMD_FWD_LOW  = 3'h3,
    HM29_CMD_FWD_HIGH = 3'h4
  } hm29_cmd_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HM29_ST_IDLE     = 3'h0,
    HM29_ST_REV_HIGH = 3'h1,
    HM29_ST_REV_LOW  = 3'h2,
    HM29_ST_FWD_LOW  = 3'h3,
    HM29_ST_FWD_HIGH = 3'h4
  } hm29_state_t;

  // ----------------------------------------------------------------
  // sub-case picked at start, set to HM29_CASE_LIMIT when the reverse limit is hit at reverse high speed
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HM29_CASE_NONE    = 2'h0,
    HM29_CASE_NO_DEC  = 2'h1,
    HM29_CASE_DEC     = 2'h2,
    HM29_CASE_LIMIT   = 2'h3
  } hm29_case_t;

endpackage

// >>> design/hm29_edge_if.sv
/*
  carrier for synchronised switch levels and their edge pulses.
  assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface hm29_edge_if;
  logic [2:0] level;
  logic [2:0] rise;
  logic [2:0] fall;

  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface

// >>> design/hm29_in_cond.sv
/*
  two-flop synchronisers and edge detectors for the switch pins.
  assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module hm29_in_cond
  import hm29_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [2:0]    pins,
  hm29_edge_if.src           edges
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;

  // ----------------------------------------------------------------
  // synchronise and keep one older sample per lane
  // ----------------------------------------------------------------
  // synchroniser runs through reset so levels are valid at release
  always_ff @(posedge sys_clk) begin
    meta_reg <= pins;
    sync_reg <= meta_reg;
  end

  // older sample for edge detection; a held pin may give one idle edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_reg <= PIN_RESET;
    end else begin
      prev_reg <= sync_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_lane
      assign edges.level[g] = sync_reg[g];
      assign edges.rise[g]  = sync_reg[g] & ~prev_reg[g];
      assign edges.fall[g]  = ~sync_reg[g] & prev_reg[g];
    end
  endgenerate

endmodule // hm29_in_cond

// >>> design/hm29_sequencer.sv
/*
  homing method 29 sequencer: drives a speed command from origin switch edges,
  the reverse limit and the deceleration point validity input.
  assumes start is a one-cycle pulse on sys_clk; switch pins are asynchronous.
*/
`timescale 1ns/1ps

module hm29_sequencer
  import hm29_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    rst,
  input  wire logic    start,
  input  wire logic    origin_pin,
  input  wire logic    rev_limit_pin,
  input  wire logic    decel_valid_pin,
  output hm29_cmd_t    cmd_reg,
  output logic         busy_reg,
  output logic         done_reg,
  output hm29_case_t   case_reg
);

  hm29_edge_if  edges ();
  hm29_state_t  state_reg;
  hm29_state_t  state_next;
  hm29_case_t   case_next;

  logic origin_rise;
  logic origin_fall;
  logic limit_on;
  logic decel_on;

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  hm29_in_cond u_in_cond (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    ({decel_valid_pin, rev_limit_pin, origin_pin}),
    .edges   (edges)
  );

  assign origin_rise = edges.rise[IDX_ORIGIN];
  assign origin_fall = edges.fall[IDX_ORIGIN];
  assign limit_on    = edges.level[IDX_LIMIT];
  assign decel_on    = edges.level[IDX_DECEL];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic hm29_cmd_t speed_of(input hm29_state_t st);
    hm29_cmd_t c;
    c = HM29_CMD_ZERO;
    case (st)
      HM29_ST_REV_HIGH: c = HM29_CMD_REV_HIGH;
      HM29_ST_REV_LOW:  c = HM29_CMD_REV_LOW;
      HM29_ST_FWD_LOW:  c = HM29_CMD_FWD_LOW;
      HM29_ST_FWD_HIGH: c = HM29_CMD_FWD_HIGH;
      default:          c = HM29_CMD_ZERO;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case_next  = case_reg;
    case (state_reg)
      HM29_ST_IDLE: begin
        if (start) begin
          if (decel_on) begin
            state_next = HM29_ST_REV_LOW;
            case_next  = HM29_CASE_DEC;
          end else begin
            state_next = HM29_ST_REV_HIGH;
            case_next  = HM29_CASE_NO_DEC;
          end
        end
      end
      HM29_ST_REV_HIGH: begin
        // limit wins over a same-cycle origin edge for safety
        if (limit_on) begin
          state_next = HM29_ST_FWD_HIGH;
          case_next  = HM29_CASE_LIMIT;
        end else if (origin_rise) begin
          state_next = HM29_ST_REV_LOW;
        end
      end
      HM29_ST_FWD_HIGH: begin
        if (origin_rise) begin
          state_next = HM29_ST_REV_LOW;
        end
      end
      HM29_ST_REV_LOW: begin
        if (origin_fall) begin
          state_next = HM29_ST_FWD_LOW;
        end
      end
      HM29_ST_FWD_LOW: begin
        if (origin_rise) begin
          state_next = HM29_ST_IDLE;
        end
      end
      default: begin
        state_next = HM29_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state and sub-case
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= HM29_ST_IDLE;
      case_reg  <= HM29_CASE_NONE;
    end else begin
      state_reg <= state_next;
      case_reg  <= case_next;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_reg  <= HM29_CMD_ZERO;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cmd_reg  <= speed_of(state_next);
      busy_reg <= (state_next != HM29_ST_IDLE);
      done_reg <= (state_reg == HM29_ST_FWD_LOW) && origin_rise;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_fwd_low_hit;
    state_reg == HM29_ST_FWD_LOW && origin_rise;
  endsequence

  sequence s_stopped;
    cmd_reg == HM29_CMD_ZERO && done_reg && !busy_reg;
  endsequence

  sequence s_limit_hit;
    state_reg == HM29_ST_REV_HIGH && limit_on;
  endsequence

  start_high_a: assert property (
    state_reg == HM29_ST_IDLE && start && !decel_on |=> cmd_reg == HM29_CMD_REV_HIGH && busy_reg)
    else $error("start without decel point did not give reverse high");

  high_to_low_a: assert property (
    state_reg == HM29_ST_REV_HIGH && origin_rise && !limit_on |=> cmd_reg == HM29_CMD_REV_LOW)
    else $error("origin rise at reverse high did not give reverse low");

  low_to_fwd_a: assert property (
    state_reg == HM29_ST_REV_LOW && origin_fall |=> cmd_reg == HM29_CMD_FWD_LOW)
    else $error("origin fall at reverse low did not give forward low");

  fwd_stop_a: assert property (
    s_fwd_low_hit |=> s_stopped ##1 !done_reg && (cmd_reg == HM29_CMD_ZERO || $past(start)))
    else $error("forward low did not stop on origin rise");

  start_low_a: assert property (
    state_reg == HM29_ST_IDLE && start && decel_on |=> cmd_reg == HM29_CMD_REV_LOW && case_reg == HM29_CASE_DEC)
    else $error("start with decel point did not give reverse low");

  dec_path_a: assert property (
    case_reg == HM29_CASE_DEC && state_reg == HM29_ST_REV_LOW && !origin_fall |=> cmd_reg == HM29_CMD_REV_LOW)
    else $error("decel case left reverse low without a falling edge");

  dec_stop_a: assert property (
    case_reg == HM29_CASE_DEC && state_reg == HM29_ST_FWD_LOW && !origin_rise |=> cmd_reg == HM29_CMD_FWD_LOW)
    else $error("decel case left forward low without a rising edge");

  limit_rev_a: assert property (
    s_limit_hit |=> cmd_reg == HM29_CMD_FWD_HIGH && case_reg == HM29_CASE_LIMIT)
    else $error("reverse limit did not turn motion to forward high");

  fwd_high_a: assert property (
    state_reg == HM29_ST_FWD_HIGH && origin_rise |=> cmd_reg == HM29_CMD_REV_LOW)
    else $error("origin rise at forward high did not give reverse low");

  edge_once_a: assert property (
    origin_rise |=> !origin_rise)
    else $error("origin rise lasted more than one cycle");

  pin_delay_a: assert property (
    $rose(origin_pin) |-> ##2 origin_rise)
    else $error("origin edge not seen within sync delay");

  idle_zero_a: assert property (
    !busy_reg |-> cmd_reg == HM29_CMD_ZERO)
    else $error("speed not zero while idle");

  case_hold_a: assert property (
    busy_reg && state_reg != HM29_ST_REV_HIGH |=> $stable(case_reg))
    else $error("sub-case changed during homing");

endmodule // hm29_sequencer

// >>> tb/hm29_motor_model.sv
/*
  behavioural motor and switch model for the homing sequencer bench.
  assumes cmd follows the package encoding; one step per sys_clk.
*/
`timescale 1ns/1ps
module hm29_motor_model
  import hm29_pkg::*;
#(
  parameter int ORG_LO = 100,
  parameter int ORG_W  = 40
)
(
  input  wire logic               sys_clk,
  input  wire logic               load,
  input  wire logic signed [15:0] load_pos,
  input  wire hm29_cmd_t          cmd,
  output logic                    origin_pin,
  output logic                    rev_limit_pin
);
  // ----------------------------------------------------------------
  // shaft position
  // ----------------------------------------------------------------
  logic signed [15:0] pos;

  always_ff @(posedge sys_clk) begin
    if (load) begin
      pos <= load_pos;
    end else begin
      case (cmd)
        HM29_CMD_REV_HIGH: pos <= pos - 16'sd4;
        HM29_CMD_REV_LOW:  pos <= pos - 16'sd1;
        HM29_CMD_FWD_LOW:  pos <= pos + 16'sd1;
        HM29_CMD_FWD_HIGH: pos <= pos + 16'sd4;
        default: ;
      endcase
    end
  end

  // origin cam covers a window; limit sits at and below zero
  assign origin_pin    = (pos >= ORG_LO) && (pos < ORG_LO + ORG_W);
  assign rev_limit_pin = (pos <= 16'sd0);
endmodule // hm29_motor_model

// >>> tb/tb_homing_method_29_sequencer.sv
/*
  self-checking bench for the homing method 29 sequencer.
  assumes the motor model closes the loop from cmd_reg to the switch pins.
*/
`timescale 1ns/1ps
module tb_homing_method_29_sequencer;
  import hm29_pkg::*;
  localparam int ORG_LO = 100;
  localparam int ORG_W  = 40;
  logic               sys_clk, rst, start, decel, load, origin, limit, busy, done;
  logic signed [15:0] lpos;
  hm29_cmd_t          cmd, last;
  hm29_case_t         cs;
  logic [14:0]        trace;
  int                 fail_count = 0, tests_run = 0, cyc = 0;

  hm29_sequencer uut (.sys_clk(sys_clk), .rst(rst), .start(start), .origin_pin(origin),
    .rev_limit_pin(limit), .decel_valid_pin(decel), .cmd_reg(cmd), .busy_reg(busy),
    .done_reg(done), .case_reg(cs));
  hm29_motor_model #(.ORG_LO(ORG_LO), .ORG_W(ORG_W)) motor (.sys_clk(sys_clk), .load(load),
    .load_pos(lpos), .cmd(cmd), .origin_pin(origin), .rev_limit_pin(limit));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // command trace and hang guard
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    last <= cmd;
    if (cmd !== last) trace <= {trace[11:0], cmd};
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [14:0] exp_trace(input logic d, input logic signed [15:0] p);
    logic [14:0] t;
    t = 15'h0000;
    if (!d) t = {t[11:0], HM29_CMD_REV_HIGH};
    if (!d && p < ORG_LO) t = {t[11:0], HM29_CMD_FWD_HIGH};
    t = {t[11:0], HM29_CMD_REV_LOW};
    t = {t[11:0], HM29_CMD_FWD_LOW};
    t = {t[11:0], HM29_CMD_ZERO};
    return t;
  endfunction

  task automatic run(input logic d, input logic signed [15:0] p);
    int n;
    hm29_case_t ec;
    ec = d ? HM29_CASE_DEC : (p < ORG_LO ? HM29_CASE_LIMIT : HM29_CASE_NO_DEC);
    load = 1'b1;
    lpos = p;
    decel = d;
    @(posedge sys_clk);
    #1 load = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 start = 1'b1;
    trace = 15'h0000;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      #1 n++;
      start = (n == 6);
    end
    chk(done, 1'b1);
    chk(cmd, HM29_CMD_ZERO);
    chk(busy, 1'b0);
    chk(cs, ec);
    @(posedge sys_clk);
    #1 chk(trace, exp_trace(d, p));
    chk(done, 1'b0);
    chk(cmd, HM29_CMD_ZERO);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    start = 1'b0;
    decel = 1'b0;
    load = 1'b1;
    lpos = 16'sd300;
    trace = 15'h0000;
    last = HM29_CMD_ZERO;
    void'($urandom(75));
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk(cmd, HM29_CMD_ZERO);
    // corners: just above the cam, just above the limit
    run(1'b0, 16'(ORG_LO + ORG_W));
    run(1'b0, 16'sd1);
    run(1'b1, 16'(ORG_LO + ORG_W));
    for (int i = 0; i < 9; i++) begin
      case (i % 3)
        0: run(1'b0, 16'(ORG_LO + ORG_W + 10 + $urandom % 200));
        1: run(1'b1, 16'(ORG_LO + ORG_W + 10 + $urandom % 200));
        default: run(1'b0, 16'(20 + $urandom % 60));
      endcase
    end
    // reset in mid-run
    load = 1'b1;
    lpos = 16'sd300;
    decel = 1'b0;
    @(posedge sys_clk);
    #1 load = 1'b0;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(cmd, HM29_CMD_ZERO);
    chk(busy, 1'b0);
    chk(cs, HM29_CASE_NONE);
    rst = 1'b0;
    // homing must work again after the mid-run reset
    run(1'b1, 16'(ORG_LO + ORG_W));
    conclude();
  end
endmodule // tb_homing_method_29_sequencer
